// ### profiler_pkg.sv
/*
 package for the miss and clock profiling event sampler: register map,
 record layout, event codes and timing constants.
 assumes an APB slave with 32-bit data and word-aligned registers.
*/
package profiler_pkg;
   // register byte offsets
   localparam logic [7:0] reg_control = 8'h00;
   localparam logic [7:0] reg_miss_interval = 8'h04;
   localparam logic [7:0] reg_clock_interval = 8'h08;
   localparam logic [7:0] reg_miss_threshold = 8'h0c;
   localparam logic [7:0] reg_miss_count = 8'h10;
   localparam logic [7:0] reg_clock_count = 8'h14;
   localparam logic [7:0] reg_capability = 8'h18;
   localparam logic [7:0] reg_record_count = 8'h1c;
   // control fields
   localparam int ctl_miss_enable = 0;
   localparam int ctl_clock_enable = 1;
   localparam int ctl_timestamp_select = 2;
   localparam int ctl_source_lo = 8;
   localparam int ctl_core_lo = 16;
   localparam logic [31:0] control_reset = 32'h0000_0000;
   localparam logic [31:0] interval_reset = 32'h0000_ffff;
   // event codes
   localparam logic [7:0] code_cache_miss = 8'h04;
   localparam logic [7:0] code_clocks = 8'h05;
   // record byte 3 field positions
   localparam int dav_bit = 4;
   localparam int source_lo = 5;
   // latency step exponent and cap exponent
   localparam int round_exp = 4;
   localparam int cap_exp = 10;
   localparam int lat_width = cap_exp - round_exp;
   // threshold is kept in units of sixteen cycles
   localparam int threshold_shift = 4;
endpackage

// ### profiling_miss_clock_events.sv
/*
 event sampler for load misses and unhalted core clocks: counts events,
 and when a counter goes negative emits a 32-byte record as four 64-bit
 words on a ready/valid stream to the ring buffer writer.
 assumes the core supplies one-cycle miss reports on pclk (the core clock),
 with latency measured by the per-load trackers below; assumes APB master.
*/
// Functional notes
// RULE1: count misses above threshold or selected source
// RULE2: negative miss counter emits record code 4
// RULE3: split load counts once, lower address
// RULE4: only direct instruction loads are counted
// RULE5: profiler's own accesses never counted
// RULE6: latency counted in 16-cycle steps
// RULE7: first step may land anywhere early
// RULE8: latency saturates at 1008, six bits
// RULE9: cap exponent readable as capability
// RULE10: threshold compared in 16-cycle units
// RULE11: data address is linear, base plus offset
// RULE12: trigger miss is reported immediately; if the emitter is busy, the next eligible miss once idle is reported
// RULE13: latency, instruction, data address placement
// RULE14: address valid flag at byte 3 bit 4
// RULE15: data source code at byte 3 bits 7:5
// RULE16: timestamp or zero in bytes 31:24
// RULE17: core identifier in byte 1
// RULE18: unhalted cycles decrement clock counter
// RULE19: clock record code 5, reserved zeroed
// RULE20: clock counter follows actual core clock
// RULE21: counter reloads after record written
`timescale 1ns/10ps
module profiling_miss_clock_events
   import profiler_pkg::*;
#(
   parameter int trackers = 4
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // per-tracker load wait: start and finish pulses
   input wire logic [trackers-1:0] load_start,
   input wire logic [trackers-1:0] load_done,
   input wire logic [$clog2(trackers)-1:0] done_index,
   input wire logic done_is_miss,
   input wire logic done_direct,
   input wire logic done_profiler_own,
   input wire logic done_split_second,
   input wire logic [2:0] done_source,
   input wire logic [63:0] done_offset,
   input wire logic [63:0] done_segment_base,
   input wire logic done_address_valid,
   input wire logic [63:0] done_instruction_pointer,
   input wire logic core_halted,
   input wire logic [63:0] retired_instruction_pointer,
   input wire logic [63:0] timestamp_counter,
   output logic [63:0] record_data,
   output logic record_valid,
   input wire logic record_ready,
   output logic record_last
);
   typedef enum {idle, emit} emit_state_type;

   logic [31:0] control;
   logic [31:0] miss_interval;
   logic [31:0] clock_interval;
   logic [31:0] miss_threshold;
   logic signed [32:0] miss_count;
   logic signed [32:0] clock_count;
   logic [31:0] record_count;
   logic [lat_width-1:0] latency [trackers];
   logic [trackers-1:0] waiting;
   logic [3:0] phase;
   emit_state_type state;
   logic [1:0] word;
   logic is_miss_record;
   logic [255:0] record;
   logic [31:0] next_latency;
   logic eligible;
   logic source_selected;
   logic miss_fire;
   logic clock_fire;
   logic apb_write;
   logic apb_read;
   logic mapped;
   logic [255:0] next_record;

   assign apb_write = psel && penable && pwrite;
   assign apb_read = psel && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_comb
   begin
      case (paddr)
         reg_control, reg_miss_interval, reg_clock_interval,
         reg_miss_threshold, reg_miss_count, reg_clock_count,
         reg_capability, reg_record_count: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // register writes with byte strobes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         control <= control_reset;
         miss_interval <= interval_reset;
         clock_interval <= interval_reset;
         miss_threshold <= 32'h0000_0000;
      end
      else if (apb_write)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (pstrb[b])
            begin
               case (paddr)
                  reg_control: control[b*8 +: 8] <= pwdata[b*8 +: 8];
                  reg_miss_interval:
                     miss_interval[b*8 +: 8] <= pwdata[b*8 +: 8];
                  reg_clock_interval:
                     clock_interval[b*8 +: 8] <= pwdata[b*8 +: 8];
                  reg_miss_threshold:
                     miss_threshold[b*8 +: 8] <= pwdata[b*8 +: 8];
                  default: ;
               endcase
            end
         end
      end
   end

   // read data is registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (apb_read && !penable)
      begin
         case (paddr)
            reg_control: prdata <= control;
            reg_miss_interval: prdata <= miss_interval;
            reg_clock_interval: prdata <= clock_interval;
            reg_miss_threshold: prdata <= miss_threshold;
            reg_miss_count: prdata <= miss_count[31:0];
            reg_clock_count: prdata <= clock_count[31:0];
            reg_capability: prdata <= {16'h0000, 8'(cap_exp),
               8'(round_exp)}; // RULE9
            reg_record_count: prdata <= record_count;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // shared step phase: first step lands anywhere in first 16 cycles
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase <= 4'h0;
      else
         phase <= phase + 4'h1; // RULE7
   end

   // per-load saturating latency trackers in 16-cycle steps
   genvar t;
   generate
      for (t = 0; t < trackers; t++)
      begin : g_track
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               latency[t] <= '0;
               waiting[t] <= 1'b0;
            end
            else if (load_start[t])
            begin
               latency[t] <= '0;
               waiting[t] <= 1'b1;
            end
            else if (load_done[t])
               waiting[t] <= 1'b0;
            else if (waiting[t] && phase == 4'hf && latency[t] != '1)
               latency[t] <= latency[t] + lat_width'(1); // RULE6 RULE8
         end
      end
   endgenerate

   assign next_latency = 32'(latency[done_index]) << round_exp; // RULE6
   assign source_selected = control[ctl_source_lo + 32'(done_source)];
   // threshold in sixteen-cycle units against measured latency
   assign eligible = done_is_miss && done_direct && !done_profiler_own
      && !done_split_second // RULE3 RULE4 RULE5
      && ((next_latency > (miss_threshold << threshold_shift))
      || source_selected); // RULE1 RULE10
   // a counter left negative by a blocked fire fires on the next event
   assign miss_fire = control[ctl_miss_enable] && state == idle
      && |load_done && eligible
      && (miss_count == 33'sd0 || miss_count[32]); // RULE2 RULE12
   assign clock_fire = control[ctl_clock_enable] && state == idle
      && !core_halted && !miss_fire
      && (clock_count == 33'sd0 || clock_count[32]); // RULE19

   // miss counter: decrement, emit on going negative, reload after
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         miss_count <= 33'sd0;
      else if (!control[ctl_miss_enable])
         miss_count <= {1'b0, miss_interval};
      else if (state == emit && is_miss_record && record_last
         && record_ready)
         miss_count <= {1'b0, miss_interval}; // RULE21
      else if (|load_done && eligible && !miss_count[32])
         miss_count <= miss_count - 33'sd1; // RULE1 RULE3
   end

   // unhalted core cycles, counted on the core clock itself
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clock_count <= 33'sd0;
      else if (!control[ctl_clock_enable])
         clock_count <= {1'b0, clock_interval};
      else if (state == emit && !is_miss_record && record_last
         && record_ready)
         clock_count <= {1'b0, clock_interval}; // RULE21
      else if (!core_halted && !clock_count[32])
         clock_count <= clock_count - 33'sd1; // RULE18 RULE20
   end

   always_comb
   begin
      next_record = '0;
      if (miss_fire)
      begin
         next_record[7:0] = code_cache_miss; // RULE2
         next_record[24 + dav_bit] = done_address_valid; // RULE14
         next_record[24 + source_lo +: 3] = done_source; // RULE15
         next_record[63:32] = next_latency; // RULE13
         next_record[127:64] = done_instruction_pointer;
         if (done_address_valid)
            next_record[191:128] = done_segment_base
               + done_offset; // RULE11 RULE13
      end
      else
      begin
         next_record[7:0] = code_clocks; // RULE19
         next_record[127:64] = retired_instruction_pointer;
      end
      next_record[15:8] = control[ctl_core_lo +: 8]; // RULE17
      if (control[ctl_timestamp_select])
         next_record[255:192] = timestamp_counter; // RULE16
   end

   // record emitter: four words, blocks new fires while busy, counting goes on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= idle;
         word <= 2'd0;
         record <= '0;
         is_miss_record <= 1'b0;
         record_count <= 32'h0000_0000;
      end
      else
      begin
         case (state)
            idle:
               if (miss_fire || clock_fire)
               begin
                  state <= emit; // RULE12
                  record <= next_record;
                  is_miss_record <= miss_fire;
                  word <= 2'd0;
               end
            emit:
               if (record_ready)
               begin
                  word <= word + 2'd1;
                  if (word == 2'd3)
                  begin
                     state <= idle;
                     record_count <= record_count + 32'h1;
                  end
               end
            default: state <= idle;
         endcase
      end
   end

   assign record_valid = state == emit;
   assign record_last = state == emit && word == 2'd3;
   assign record_data = record[64*word +: 64];

   a_miss_code: assert property // RULE2
      (@(posedge pclk) disable iff (!presetn)
      miss_fire |=> record_data[7:0] == code_cache_miss)
      else $error("miss record code wrong");
   a_clock_code: assert property // RULE19
      (@(posedge pclk) disable iff (!presetn)
      clock_fire |=> record_data[7:0] == code_clocks)
      else $error("clock record code wrong");
   a_own_excluded: assert property // RULE5
      (@(posedge pclk) disable iff (!presetn)
      (|load_done && done_profiler_own && !clock_fire
      && !(state == emit && is_miss_record))
      |=> $stable(miss_count))
      else $error("own access counted");
   a_clock_decr: assert property // RULE18
      (@(posedge pclk) disable iff (!presetn)
      (control[ctl_clock_enable] && $past(control[ctl_clock_enable])
      && !core_halted && !clock_count[32] && state == idle)
      |=> clock_count == $past(clock_count) - 33'sd1)
      else $error("clock counter not decremented");
   a_halt_hold: assert property // RULE18
      (@(posedge pclk) disable iff (!presetn)
      (control[ctl_clock_enable] && core_halted && state == idle)
      |=> clock_count == $past(clock_count))
      else $error("counted while halted");
   a_latency_cap: assert property // RULE8
      (@(posedge pclk) disable iff (!presetn)
      next_latency <= 32'd1008)
      else $error("latency beyond cap");
   a_latency_step: assert property // RULE6
      (@(posedge pclk) disable iff (!presetn)
      next_latency[3:0] == 4'h0)
      else $error("latency not in steps");
   a_reload: assert property // RULE21
      (@(posedge pclk) disable iff (!presetn)
      (state == emit && is_miss_record && record_last && record_ready
      && control[ctl_miss_enable])
      |=> miss_count == {1'b0, $past(miss_interval)})
      else $error("miss counter not reloaded");
   a_core_field: assert property // RULE17
      (@(posedge pclk) disable iff (!presetn)
      (miss_fire || clock_fire)
      |=> record_data[15:8] == $past(control[ctl_core_lo +: 8]))
      else $error("core id wrong");
   a_split_once: assert property // RULE3
      (@(posedge pclk) disable iff (!presetn)
      (|load_done && done_split_second && control[ctl_miss_enable]
      && !(state == emit && is_miss_record))
      |=> $stable(miss_count))
      else $error("second half of split load counted");
   a_indirect_excluded: assert property // RULE4
      (@(posedge pclk) disable iff (!presetn)
      (|load_done && !done_direct && control[ctl_miss_enable]
      && !(state == emit && is_miss_record))
      |=> $stable(miss_count))
      else $error("indirect miss counted");
   a_miss_decr: assert property // RULE1
      (@(posedge pclk) disable iff (!presetn)
      (control[ctl_miss_enable] && |load_done && eligible
      && !miss_count[32] && state == idle)
      |=> miss_count == $past(miss_count) - 33'sd1)
      else $error("eligible miss not counted");
   a_address_flag: assert property // RULE14
      (@(posedge pclk) disable iff (!presetn)
      miss_fire |=> record[24 + dav_bit] == $past(done_address_valid))
      else $error("address valid flag wrong");
   a_no_address: assert property // RULE14
      (@(posedge pclk) disable iff (!presetn)
      (miss_fire && !done_address_valid) |=> record[191:128] == 64'h0)
      else $error("unavailable address not zero");
   a_source_field: assert property // RULE15
      (@(posedge pclk) disable iff (!presetn)
      miss_fire |=> record[24 + source_lo +: 3] == $past(done_source))
      else $error("data source code wrong");
   a_clock_reserved: assert property // RULE19
      (@(posedge pclk) disable iff (!presetn)
      clock_fire |=> record[63:16] == 48'h0 && record[191:128] == 64'h0)
      else $error("clock record reserved bytes not zero");
   a_no_timestamp: assert property // RULE16
      (@(posedge pclk) disable iff (!presetn)
      ((miss_fire || clock_fire) && !control[ctl_timestamp_select])
      |=> record[255:192] == 64'h0)
      else $error("timestamp present without select");
   a_word_hold: assert property // RULE13
      (@(posedge pclk) disable iff (!presetn)
      (record_valid && !record_ready)
      |=> record_valid && $stable(record_data))
      else $error("record word changed while stalled");
endmodule

// ### ring_sink.sv
/*
 partner model of the event ring buffer writer: takes record words
 from the sampler's stream, with random stalls on record_ready.
 assumes the bench seeds the random generator and reads the queue.
*/
`timescale 1ns/10ps
module ring_sink
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [63:0] record_data,
   input wire logic record_valid,
   input wire logic record_last,
   output logic record_ready
);
   logic [64:0] words[$];
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         record_ready <= 1'b0;
      else
      begin
         if (record_valid && record_ready)
            words.push_back({record_last, record_data});
         // stall about one cycle in three
         record_ready <= 1'(($urandom % 3) != 0);
      end
endmodule

// ### tb_profiling_miss_clock_events.sv
/*
 self-checking bench for the miss and clock event sampler.
 assumes ring_sink as the record consumer and a zero-wait APB slave.
*/
`timescale 1ns/10ps
module tb_profiling_miss_clock_events;
   import profiler_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, load_start, load_done;
   logic [1:0] done_index;
   logic done_is_miss, done_direct, done_profiler_own, done_split_second;
   logic [2:0] done_source;
   logic [63:0] done_offset, done_segment_base, done_instruction_pointer;
   logic done_address_valid, core_halted, record_valid, record_ready;
   logic record_last, clk_on, clk_fired;
   logic [63:0] retired_instruction_pointer, timestamp_counter;
   logic [63:0] record_data, clk_ip;
   int failures, samples_checked, mcnt, mint, ccnt, nrec;
   int wt[8] = '{200, 200, 200, 200, 8, 8, 200, 1100};
   logic [3:0] ft[8] = '{4'h4, 4'h8, 4'he, 4'hd, 4'hc, 4'hc, 4'hc, 4'hc};
   logic [2:0] st[8] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h3, 3'h1, 3'h2};

   profiling_miss_clock_events profiling_miss_clock_events_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .load_start(load_start), .load_done(load_done),
      .done_index(done_index), .done_is_miss(done_is_miss),
      .done_direct(done_direct), .done_profiler_own(done_profiler_own),
      .done_split_second(done_split_second), .done_source(done_source),
      .done_offset(done_offset), .done_segment_base(done_segment_base),
      .done_address_valid(done_address_valid),
      .done_instruction_pointer(done_instruction_pointer),
      .core_halted(core_halted),
      .retired_instruction_pointer(retired_instruction_pointer),
      .timestamp_counter(timestamp_counter), .record_data(record_data),
      .record_valid(record_valid), .record_ready(record_ready),
      .record_last(record_last));
   ring_sink ring_sink_i (.pclk(pclk), .presetn(presetn),
      .record_data(record_data), .record_valid(record_valid),
      .record_last(record_last), .record_ready(record_ready));

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   always @(posedge pclk)
      retired_instruction_pointer <= {$urandom, $urandom};

   // clock event model: fires on an unhalted cycle with count at zero
   always @(posedge pclk)
      if (clk_on && !clk_fired && !core_halted)
      begin
         if (ccnt == 0)
         begin
            clk_ip <= retired_instruction_pointer;
            clk_fired <= 1'b1;
         end
         else
            ccnt--;
      end

   task automatic stop_test;
      if (failures == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk({32'h0, rd}, {32'h0, e});
   endtask

   task automatic take_rec(input logic [63:0] w0, input int lat,
      input logic [63:0] w1, input logic [63:0] w2, input logic [63:0] w3);
      logic [64:0] g;
      logic [3:0] lasts;
      logic ok;
      int n, lo, hi;
      n = 0;
      while (ring_sink_i.words.size() < 4 && n < 1000)
      begin
         @(posedge pclk);
         n++;
      end
      chk(64'(ring_sink_i.words.size()), 64'h4);
      if (ring_sink_i.words.size() < 4)
         return;
      nrec++;
      lo = lat < 16 ? 0 : (lat - 16 > 1008 ? 1008 : lat - 16);
      hi = lat < 0 ? 0 : (lat + 16 > 1008 ? 1008 : lat + 16);
      g = ring_sink_i.words.pop_front();
      lasts[0] = g[64];
      chk({32'h0, g[31:0]}, w0);
      ok = g[63:32] >= lo && g[63:32] <= hi && g[35:32] == 4'h0;
      samples_checked++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, g[63:32], hi);
      end
      for (int k = 1; k < 4; k++)
      begin
         g = ring_sink_i.words.pop_front();
         lasts[k] = g[64];
         chk(g[63:0], k == 1 ? w1 : k == 2 ? w2 : w3);
      end
      chk(64'(lasts), 64'h8);
   endtask

   task automatic load(input int w, input logic [3:0] f,
      input logic [2:0] s, input logic ts);
      logic [1:0] t;
      logic [63:0] lin;
      logic data_address_valid;
      t = 2'($urandom);
      data_address_valid = 1'($urandom);
      done_address_valid <= data_address_valid;
      load_start[t] <= 1'b1;
      done_index <= t;
      {done_is_miss, done_direct, done_profiler_own, done_split_second} <= f;
      done_source <= s;
      done_offset <= {$urandom, $urandom};
      done_segment_base <= {$urandom, $urandom};
      done_instruction_pointer <= {$urandom, $urandom};
      @(posedge pclk);
      load_start <= 4'h0;
      lin = done_offset + done_segment_base;
      repeat (w - 1) @(posedge pclk);
      load_done[t] <= 1'b1;
      @(posedge pclk);
      load_done <= 4'h0;
      // threshold 4 units: 64 cycles, long waits clear it by a margin
      if (f == 4'hc && (w > 80 || s == 3'h3))
      begin
         if (mcnt == 0)
         begin
            take_rec({32'h0, s, data_address_valid, 4'h0, 8'h00, 8'h5a, code_cache_miss}, w,
               done_instruction_pointer, data_address_valid ? lin : 64'h0,
               ts ? timestamp_counter : 64'h0);
            mcnt = mint;
         end
         else
            mcnt--;
      end
      repeat (4) @(posedge pclk);
      rchk(reg_miss_count, 32'(mcnt));
   endtask

   initial
   begin
      void'($urandom(32'h08c272fd));
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {load_start, load_done, done_index, done_source} = '0;
      {done_is_miss, done_direct, done_profiler_own} = '0;
      {done_split_second, done_offset, done_segment_base} = '0;
      done_instruction_pointer = 64'h0;
      done_address_valid = 1'b1;
      {core_halted, timestamp_counter, clk_on, clk_fired} = '0;
      retired_instruction_pointer = 64'h0;
      pstrb = 4'hf;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(reg_miss_count, interval_reset);
      apb(1'b1, reg_capability, 32'hffff_ffff);
      rchk(reg_capability, 32'h0000_0a04);
      apb(1'b0, 8'h20, 32'h0);
      chk(64'(err), 64'h1);
      for (int p = 0; p < 2; p++)
      begin
         mint = p ? 0 : 2;
         mcnt = mint;
         apb(1'b1, reg_control, 32'h0);
         apb(1'b1, reg_miss_interval, 32'(mint));
         apb(1'b1, reg_miss_threshold, 32'h4);
         apb(1'b1, reg_control, p ? 32'h005a_0801 : 32'h005a_0805);
         timestamp_counter <= {$urandom, $urandom};
         for (int i = 0; i < 8; i++)
            load(wt[i], ft[i], st[i], p == 0);
      end
      core_halted <= 1'b1;
      apb(1'b1, reg_control, 32'h0);
      apb(1'b1, reg_clock_interval, 32'h1e);
      apb(1'b1, reg_control, 32'h005a_0006);
      ccnt = 30;
      clk_on = 1'b1;
      for (int n = 0; n < 400 && !clk_fired; n++)
      begin
         core_halted <= 1'($urandom);
         @(posedge pclk);
      end
      core_halted <= 1'b1;
      take_rec({32'h0, 8'h00, 8'h00, 8'h5a, code_clocks}, -1, clk_ip,
         64'h0, timestamp_counter);
      apb(1'b1, reg_control, 32'h0);
      rchk(reg_record_count, 32'(nrec));
      stop_test();
   end

   initial
   begin
      repeat (40000) @(posedge pclk);
      failures++;
      stop_test();
   end
endmodule
